// ==== mtg_pkg.sv ====
// package for the multi-mode timer group: modes, config carrier, constants
package mtg_pkg;

  // count clock prescaler ratio of the 100 MHz clock
  localparam int unsigned MTG_PRESCALE_DIV = 4;
  // reset values and the 8-bit count maximum
  localparam logic [7:0]  MTG_CNT8_RST  = 8'h00;
  localparam logic [15:0] MTG_CNT16_RST = 16'h0000;
  localparam logic        MTG_OUT_RST   = 1'b0;
  localparam logic [7:0]  MTG_CNT8_MAX  = 8'hFF;

  // operating mode of the channel a / channel b pair
  typedef enum logic [1:0] {
    MTG_AB_STANDALONE = 2'b00,
    MTG_AB_CASCADE    = 2'b01,
    MTG_AB_CARRIER    = 2'b10,
    MTG_AB_PWM        = 2'b11
  } mtg_ab_mode_e;

  // operating mode of channel c
  typedef enum logic [1:0] {
    MTG_C_STANDALONE = 2'b00,
    MTG_C_PPG        = 2'b01,
    MTG_C_EVENT24    = 2'b10,
    MTG_C_STOP       = 2'b11
  } mtg_c_mode_e;

  // wide timer output pin action on compare match
  typedef enum logic [1:0] {
    MTG_ACT_NONE   = 2'b00,
    MTG_ACT_TOGGLE = 2'b01,
    MTG_ACT_SET    = 2'b10,
    MTG_ACT_CLEAR  = 2'b11
  } mtg_act_e;

  // software-written mode and value settings
  typedef struct packed {
    mtg_ab_mode_e ab_mode;
    mtg_c_mode_e  c_mode;
    logic         a_run;
    logic         b_run;
    logic         c_run;
    logic         w_run;
    logic         b_ext;       // b counts its event pin
    logic         c_ext;       // c counts its event pin
    logic         b_ppg;       // b pulse generator in stand-alone or pwm pair mode
    logic [7:0]   a_cmp;
    logic [7:0]   b_cmp;
    logic [7:0]   c_cmp;
    logic [7:0]   a_width;
    logic [7:0]   b_width;
    logic [7:0]   c_width;
    logic [15:0]  w_cmp;
    mtg_act_e     w_act;
  } mtg_cfg_s;

  // result of one interval-counter step
  typedef struct packed {
    logic [7:0] cnt;
    logic       hit;
  } mtg_step_s;

endpackage : mtg_pkg

// ==== mtg_timer_group.sv ====
// multi-mode timer group: three 8-bit channels and a 16-bit capture timer
// Function
// R1: channels a, b and c each run alone as an 8-bit timer counter.
// R2: stand-alone gives interval timer and square wave; a offers only these.
// R3: stand-alone b and c may count their own external event pins.
// R4: a and b cascade into one 16-bit counter; c never cascades.
// R5: cascade gives 16-bit interval timer, event counter and square wave.
// R6: carrier mode outputs b's carrier gated by a's cycle; only a/b.
// R7: only a does pwm: programmable duty, fixed free-running overflow period.
// R8: b and c pulse generator: software sets both period and width.
// R9: c chained with wide timer forms 24-bit event counter; only c.
// R10: 24-bit event counting is read only: no compare, match or clear.
// R11: mode comes from software settings; only listed channel/mode pairs exist.
// R12: wide timer raises interrupt when count equals compare value.
// R13: wide timer performs configured output pin action at each match.
// R14: capture trigger copies wide count into capture register, held till next.
// R15: b irq on 8-bit match, or on combined a/b match when cascaded.
// R16: outside world supplies event pulses on b and c event pins.
// R17: square-wave output toggles at every compare match.
`timescale 1ns/10ps
`default_nettype none

module mtg_timer_group
  import mtg_pkg::*;
#(
  parameter int unsigned PRESCALE_DIV = MTG_PRESCALE_DIV
) (
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_b_i,
  // settings from software
  input  wire mtg_cfg_s  cfg_i,
  // pins
  input  wire logic      channel_b_event_input_i,
  input  wire logic      channel_c_event_input_i,
  input  wire logic      capture_trigger_input_i,
  output logic           channel_a_output_o,
  output logic           channel_b_output_o,
  output logic           channel_c_output_o,
  output logic           wide_timer_output_o,
  // interrupt pulses
  output logic           channel_a_match_irq_o,
  output logic           channel_b_match_irq_o,
  output logic           channel_c_match_irq_o,
  output logic           wide_timer_match_irq_o,
  // count readback
  output logic [7:0]     channel_a_counter_o,
  output logic [7:0]     channel_b_counter_o,
  output logic [7:0]     channel_c_counter_o,
  output logic [15:0]    wide_timer_o,
  output logic [15:0]    capture_o
);

  localparam int unsigned PW = (PRESCALE_DIV > 1) ? $clog2(PRESCALE_DIV) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE_DIV - 1);

  // whole state of the block
  typedef struct packed {
    logic [PW-1:0] pre;
    logic [1:0]    b_sync;
    logic [1:0]    c_sync;
    logic [1:0]    t_sync;
    logic          b_prev;
    logic          c_prev;
    logic          t_prev;
    logic [7:0]    a_cnt;
    logic [7:0]    b_cnt;
    logic [7:0]    c_cnt;
    logic [15:0]   w_cnt;
    logic [15:0]   cap;
    logic          a_tog;
    logic          b_tog;
    logic          c_tog;
    logic          a_out;
    logic          b_out;
    logic          c_out;
    logic          w_out;
    logic          a_irq;
    logic          b_irq;
    logic          c_irq;
    logic          w_irq;
  } mtg_state_s;

  mtg_state_s s;
  mtg_state_s next_s;

  // interval step: clears to zero on the count after reaching the compare value
  function automatic mtg_step_s step8(input logic [7:0] cnt, input logic [7:0] cmp,
                                      input logic en);
    mtg_step_s r;
    r.cnt = cnt;
    r.hit = 1'b0;
    if (en) begin
      if (cnt == cmp) begin
        r.cnt = MTG_CNT8_RST;
        r.hit = 1'b1;
      end else begin
        r.cnt = cnt + 8'h01;
      end
    end
    return r;
  endfunction : step8

  // next-state logic
  always_comb begin
    logic      tick;
    logic      b_edge;
    logic      c_edge;
    logic      t_edge;
    logic      b_ev;
    logic      c_ev;
    logic      ab_ev;
    mtg_step_s sa;
    mtg_step_s sb;
    mtg_step_s sc;
    logic [15:0] ab;
    tick   = 1'b0;
    b_edge = 1'b0;
    c_edge = 1'b0;
    t_edge = 1'b0;
    b_ev   = 1'b0;
    c_ev   = 1'b0;
    ab_ev  = 1'b0;
    sa     = '0;
    sb     = '0;
    sc     = '0;
    ab     = '0;
    next_s = s;
    next_s.a_irq = 1'b0;
    next_s.b_irq = 1'b0;
    next_s.c_irq = 1'b0;
    next_s.w_irq = 1'b0;

    // count clock enable from the divider
    if (s.pre == PRE_LAST) begin
      next_s.pre = '0;
      tick       = 1'b1;
    end else begin
      next_s.pre = s.pre + PW'(1);
    end

    // pin synchronisers; edges are taken from the second stage only
    next_s.b_sync = {s.b_sync[0], channel_b_event_input_i};
    next_s.c_sync = {s.c_sync[0], channel_c_event_input_i};
    next_s.t_sync = {s.t_sync[0], capture_trigger_input_i};
    next_s.b_prev = s.b_sync[1];
    next_s.c_prev = s.c_sync[1];
    next_s.t_prev = s.t_sync[1];
    b_edge = s.b_sync[1] & ~s.b_prev;
    c_edge = s.c_sync[1] & ~s.c_prev;
    t_edge = s.t_sync[1] & ~s.t_prev;

    // R3 R16 event pin or internal count clock for b and c
    b_ev = cfg_i.b_ext ? b_edge : tick;
    c_ev = cfg_i.c_ext ? c_edge : tick;

    // R11 the a/b pair mode picks one of the legal combinations
    unique case (cfg_i.ab_mode)
      MTG_AB_CASCADE: begin
        // R4 R5 combined counter, b on top, count source follows b's choice
        ab_ev = cfg_i.b_ext ? b_edge : tick;
        ab    = {s.b_cnt, s.a_cnt};
        if (cfg_i.a_run && cfg_i.b_run && ab_ev) begin
          // R15 combined match drives b's interrupt
          if (ab == {cfg_i.b_cmp, cfg_i.a_cmp}) begin
            ab           = MTG_CNT16_RST;
            next_s.b_irq = 1'b1;
            next_s.b_tog = ~s.b_tog;
          end else begin
            ab = ab + 16'h0001;
          end
        end
        next_s.b_cnt = ab[15:8];
        next_s.a_cnt = ab[7:0];
        // R17 16-bit square wave on b's pin
        next_s.b_out = s.b_tog;
      end
      MTG_AB_PWM: begin
        // R7 free-running a, period is its 256-count overflow
        if (cfg_i.a_run && tick) begin
          next_s.a_cnt = s.a_cnt + 8'h01;
        end
        next_s.a_out = (s.a_cnt < cfg_i.a_width);
        next_s.a_irq = cfg_i.a_run && tick && (s.a_cnt == MTG_CNT8_MAX);
        // b keeps running on its own meanwhile
        sb = step8(s.b_cnt, cfg_i.b_cmp, cfg_i.b_run && b_ev);
        next_s.b_cnt = sb.cnt;
        next_s.b_irq = sb.hit;
        if (sb.hit) begin
          next_s.b_tog = ~s.b_tog;
        end
        next_s.b_out = cfg_i.b_ppg ? (s.b_cnt < cfg_i.b_width) : s.b_tog;
      end
      MTG_AB_STANDALONE, MTG_AB_CARRIER: begin
        // R1 R2 stand-alone a: interval timer and square wave
        sa = step8(s.a_cnt, cfg_i.a_cmp, cfg_i.a_run && tick);
        next_s.a_cnt = sa.cnt;
        next_s.a_irq = sa.hit;
        // R17 toggle at each match
        if (sa.hit) begin
          next_s.a_tog = ~s.a_tog;
        end
        next_s.a_out = s.a_tog;
        // R1 R15 stand-alone b with its 8-bit match interrupt
        sb = step8(s.b_cnt, cfg_i.b_cmp, cfg_i.b_run && b_ev);
        next_s.b_cnt = sb.cnt;
        next_s.b_irq = sb.hit;
        if (sb.hit) begin
          next_s.b_tog = ~s.b_tog;
        end
        if (cfg_i.ab_mode == MTG_AB_CARRIER) begin
          // R6 b's carrier passes only while a's cycle gate is high
          next_s.b_out = s.b_tog & s.a_tog;
        end else if (cfg_i.b_ppg) begin
          // R8 compare sets the period, width sets the high time
          next_s.b_out = (s.b_cnt < cfg_i.b_width);
        end else begin
          next_s.b_out = s.b_tog;
        end
      end
    endcase

    // channel c and the wide timer
    if (cfg_i.c_mode == MTG_C_EVENT24) begin
      // R9 c counts pin events, its overflow carries into the wide timer
      if (cfg_i.c_run && c_edge) begin
        next_s.c_cnt = s.c_cnt + 8'h01;
        if (s.c_cnt == MTG_CNT8_MAX) begin
          next_s.w_cnt = s.w_cnt + 16'h0001;
        end
      end
      // R10 no compare, no match, no clear while chained
    end else begin
      if (cfg_i.c_mode != MTG_C_STOP) begin
        // R1 R3 stand-alone c
        sc = step8(s.c_cnt, cfg_i.c_cmp, cfg_i.c_run && c_ev);
        next_s.c_cnt = sc.cnt;
        next_s.c_irq = sc.hit;
        if (sc.hit) begin
          next_s.c_tog = ~s.c_tog;
        end
        // R8 pulse generator, else R17 square wave
        next_s.c_out = (cfg_i.c_mode == MTG_C_PPG) ? (s.c_cnt < cfg_i.c_width) : s.c_tog;
      end
      // wide timer free-runs on the count clock
      if (cfg_i.w_run && tick) begin
        next_s.w_cnt = s.w_cnt + 16'h0001;
        if (s.w_cnt == cfg_i.w_cmp) begin
          // R12 match interrupt
          next_s.w_irq = 1'b1;
          // R13 configured pin action
          unique case (cfg_i.w_act)
            MTG_ACT_TOGGLE: next_s.w_out = ~s.w_out;
            MTG_ACT_SET:    next_s.w_out = 1'b1;
            MTG_ACT_CLEAR:  next_s.w_out = 1'b0;
            MTG_ACT_NONE:   next_s.w_out = s.w_out;
          endcase
        end
      end
    end

    // R14 capture holds until the next trigger edge
    if (t_edge) begin
      next_s.cap = s.w_cnt;
    end
  end

  // state register; all outputs come straight from these flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s       <= '0;
      s.a_cnt <= MTG_CNT8_RST;
      s.b_cnt <= MTG_CNT8_RST;
      s.c_cnt <= MTG_CNT8_RST;
      s.w_cnt <= MTG_CNT16_RST;
      s.cap   <= MTG_CNT16_RST;
      s.w_out <= MTG_OUT_RST;
    end else begin
      s <= next_s;
    end
  end

  // port map of state fields
  assign channel_a_output_o     = s.a_out;
  assign channel_b_output_o     = s.b_out;
  assign channel_c_output_o     = s.c_out;
  assign wide_timer_output_o    = s.w_out;
  assign channel_a_match_irq_o  = s.a_irq;
  assign channel_b_match_irq_o  = s.b_irq;
  assign channel_c_match_irq_o  = s.c_irq;
  assign wide_timer_match_irq_o = s.w_irq;
  assign channel_a_counter_o    = s.a_cnt;
  assign channel_b_counter_o    = s.b_cnt;
  assign channel_c_counter_o    = s.c_cnt;
  assign wide_timer_o           = s.w_cnt;
  assign capture_o              = s.cap;

endmodule : mtg_timer_group

`default_nettype wire

// ==== mtg_timer_group_asserts.sv ====
// port checks for the multi-mode timer group
`timescale 1ns/10ps
`default_nettype none

module mtg_timer_group_asserts
  import mtg_pkg::*;
(
  // clock, reset and inputs
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire mtg_cfg_s    cfg_i,
  input wire logic        capture_trigger_input_i,
  // watched outputs
  input wire logic        channel_a_output_o,
  input wire logic        channel_b_output_o,
  input wire logic        channel_c_output_o,
  input wire logic        channel_a_match_irq_o,
  input wire logic        channel_b_match_irq_o,
  input wire logic        wide_timer_match_irq_o,
  input wire logic        wide_timer_output_o,
  input wire logic [7:0]  channel_a_counter_o,
  input wire logic [7:0]  channel_b_counter_o,
  input wire logic [7:0]  channel_c_counter_o,
  input wire logic [15:0] wide_timer_o,
  input wire logic [15:0] capture_o
);
  mtg_ab_mode_e ab;

  // pair mode, shortened for the properties below
  assign ab = cfg_i.ab_mode;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  AST_A_HIT: assert property (ab == MTG_AB_STANDALONE && channel_a_match_irq_o
    |-> channel_a_counter_o == 8'h00 && $past(channel_a_counter_o) == $past(cfg_i.a_cmp))
    else $error("a irq away from its compare value");
  AST_A_SQW: assert property (ab == MTG_AB_STANDALONE && $changed(channel_a_output_o)
    |-> $past(channel_a_match_irq_o)) else $error("a square pin moved without a match");
  AST_B_CASC: assert property (ab == MTG_AB_CASCADE && channel_b_match_irq_o
    |-> $past({channel_b_counter_o, channel_a_counter_o}) == $past({cfg_i.b_cmp, cfg_i.a_cmp}))
    else $error("cascade irq away from combined compare");
  // first edge after release still shows the reset level of the pin
  AST_PWM: assert property ($past(rst_b_i) && ab == MTG_AB_PWM && $past(ab) == MTG_AB_PWM
    |-> channel_a_output_o == ($past(channel_a_counter_o) < $past(cfg_i.a_width)))
    else $error("pwm pin does not follow duty");
  AST_W_HIT: assert property (wide_timer_match_irq_o
    |-> $past(wide_timer_o) == $past(cfg_i.w_cmp)) else $error("wide irq off compare");
  AST_W_SET: assert property (wide_timer_match_irq_o && cfg_i.w_act == MTG_ACT_SET
    |-> ##[0:1] wide_timer_output_o) else $error("wide pin not set on match");
  AST_W_EV24: assert property ($past(cfg_i.c_mode) == MTG_C_EVENT24
    |-> !wide_timer_match_irq_o) else $error("match raised in event chain mode");
  AST_C_STOP: assert property ($past(cfg_i.c_mode) == MTG_C_STOP
    |-> $stable(channel_c_counter_o)) else $error("stopped c counter moved");
  AST_CAPT: assert property ($changed(capture_o)
    |-> $past(capture_trigger_input_i, 2) || $past(capture_trigger_input_i, 3))
    else $error("capture moved without trigger");
  // pin and gate come from the same toggle state, so a carrier high needs a high gate
  AST_CARR: assert property ($past(ab) == MTG_AB_CARRIER && channel_b_output_o
    |-> channel_a_output_o) else $error("carrier pulse outside the a gate");
  AST_B_PPG: assert property ($past(rst_b_i) && $past(cfg_i.b_ppg)
    && ($past(ab) == MTG_AB_STANDALONE || $past(ab) == MTG_AB_PWM)
    |-> channel_b_output_o == ($past(channel_b_counter_o) < $past(cfg_i.b_width)))
    else $error("b pulse pin does not follow width");
  AST_C_PPG: assert property ($past(rst_b_i) && $past(cfg_i.c_mode) == MTG_C_PPG
    |-> channel_c_output_o == ($past(channel_c_counter_o) < $past(cfg_i.c_width)))
    else $error("c pulse pin does not follow width");

  COV_CASC: cover property (channel_b_match_irq_o && ab == MTG_AB_CASCADE);
  COV_CAPT: cover property ($changed(capture_o));
  COV_WIDE: cover property (wide_timer_match_irq_o);
  COV_PPG: cover property ($past(cfg_i.c_mode) == MTG_C_PPG && $rose(channel_c_output_o));
endmodule : mtg_timer_group_asserts

bind mtg_timer_group mtg_timer_group_asserts u_asserts (.*);

`default_nettype wire

// ==== mtg_partner.sv ====
// event and capture pin source standing in for the outside world
`timescale 1ns/10ps
`default_nettype none

module mtg_partner (
  // clock and request: bit 0 b event, bit 1 c event, bit 2 capture
  input  wire logic       clk_i,
  input  wire logic [2:0] req_i,
  input  wire logic       slow_i,
  // pins and status
  output logic      [2:0] pin_o,
  output logic            busy_o
);
  // one pulse per request, pins idle low between requests
  // high and low at least three cycles each, or the pin sync misses it
  initial begin
    pin_o = 3'h0;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (req_i != 3'h0) begin
        busy_o <= 1'b1;
        pin_o <= req_i;
        repeat (slow_i ? 6 : 3) @(posedge clk_i);
        pin_o <= 3'h0;
        repeat (slow_i ? 6 : 3) @(posedge clk_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule : mtg_partner

`default_nettype wire

// ==== mtg_timer_group_tb.sv ====
// self-checking bench for the timer group, scoreboarded on irq pulses
`timescale 1ns/10ps
`default_nettype none

module mtg_timer_group_tb
  import mtg_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  mtg_cfg_s    cfg = '0;
  logic [2:0]  req = 3'h0;
  logic        slow = 1'b0;
  logic [2:0]  pin;
  logic        busy;
  logic        w_o, a_q, b_q, c_q, w_q;
  logic [7:0]  b_n, c_n;
  logic [15:0] w_n, cap;
  logic [3:0]  watch = 4'h0;
  logic [3:0]  hit;
  logic [3:0]  notes[$];
  logic [31:0] seed = 32'h2b9f_b8e3;
  int          num_errors = 0;
  int          comparisons = 0;

  // clock and the irq lines this test is listening to
  always #5 clk_i = ~clk_i;
  assign hit = {a_q, b_q, c_q, w_q} & watch;

  mtg_timer_group #(.PRESCALE_DIV(1)) uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg),
    .channel_b_event_input_i(pin[0]), .channel_c_event_input_i(pin[1]),
    .capture_trigger_input_i(pin[2]), .channel_a_output_o(), .channel_b_output_o(),
    .channel_c_output_o(), .wide_timer_output_o(w_o), .channel_a_match_irq_o(a_q),
    .channel_b_match_irq_o(b_q), .channel_c_match_irq_o(c_q), .wide_timer_match_irq_o(w_q),
    .channel_a_counter_o(), .channel_b_counter_o(b_n), .channel_c_counter_o(c_n),
    .wide_timer_o(w_n), .capture_o(cap));
  mtg_partner far (.clk_i(clk_i), .req_i(req), .slow_i(slow), .pin_o(pin), .busy_o(busy));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // an irq with no note waiting is itself a mismatch
  always @(posedge clk_i) begin
    if (hit != 4'h0 && notes.size() == 0)
      check("irq", 16'h0000, {12'h000, hit});
    else if (hit != 4'h0)
      check("irq", {12'h000, notes.pop_front()}, {12'h000, hit});
  end

  task automatic expect_irq(input logic [3:0] v, input int bound);
    notes.push_back(v);
    for (int i = 0; i < bound && notes.size() != 0; i++) @(posedge clk_i);
    if (notes.size() != 0) begin
      num_errors++;
      results();
    end
  endtask : expect_irq

  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 40 && busy !== lvl; i++) @(posedge clk_i);
    if (busy !== lvl) begin
      num_errors++;
      results();
    end
  endtask : wait_busy

  // hold the request until the partner takes it, random pulse speed
  task automatic pulse(input logic [2:0] m);
    logic [31:0] r;
    r = rnd();
    req <= m;
    slow <= r[0];
    wait_busy(1'b1);
    req <= 3'h0;
    wait_busy(1'b0);
  endtask : pulse

  task automatic do_reset(input mtg_cfg_s k);
    cfg <= k;
    watch <= 4'h0;
    rst_b_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset

  initial begin
    mtg_cfg_s k;
    logic [31:0] r;
    r = rnd();
    k = '0;
    k.c_mode = MTG_C_EVENT24;
    k.c_run = 1'b1;
    k.w_run = 1'b1;
    do_reset(k);
    watch <= 4'h1;
    repeat (256 + r[2:0]) pulse(3'h2);
    check("chain low", {13'h0000, r[2:0]}, {8'h00, c_n});
    check("chain high", 16'h0001, w_n);
    pulse(3'h4);
    pulse(3'h2);
    check("capture", 16'h0001, cap);
    $display("test done: event chain and capture");
    for (int m = 0; m < 4; m++) begin
      r = rnd();
      k = '0;
      k.ab_mode = mtg_ab_mode_e'(m[1:0]);
      k.a_run = 1'b1;
      k.b_run = 1'b1;
      k.a_cmp = {4'h0, r[3:0]} + 8'h01;
      k.b_cmp = 8'h01;
      k.a_width = r[15:8];
      k.b_ppg = r[4];
      k.b_width = r[23:16];
      do_reset(k);
      watch <= (m == 1) ? 4'h4 : 4'h8;
      repeat (2) expect_irq((m == 1) ? 4'h4 : 4'h8, 600);
      $display("test done: pair mode %0d", m);
    end
    r = rnd();
    k = '0;
    k.b_run = 1'b1;
    k.c_run = 1'b1;
    k.b_ext = 1'b1;
    k.c_ext = 1'b1;
    k.b_cmp = 8'hFF;
    k.c_cmp = 8'hFF;
    do_reset(k);
    repeat (r[1:0] + 1) pulse(3'h1);
    repeat (r[3:2] + 1) pulse(3'h2);
    check("b events", {14'h0000, r[1:0]} + 16'h0001, {8'h00, b_n});
    k.c_mode = MTG_C_STOP;
    cfg <= k;
    pulse(3'h2);
    check("c events", {14'h0000, r[3:2]} + 16'h0001, {8'h00, c_n});
    k.c_mode = MTG_C_PPG;
    k.c_ext = 1'b0;
    k.c_cmp = 8'h03;
    k.c_width = 8'h01;
    cfg <= k;
    watch <= 4'h2;
    repeat (2) expect_irq(4'h2, 300);
    $display("test done: events, stop and pulse generator");
    k = '0;
    k.w_run = 1'b1;
    k.w_cmp = {8'h00, r[11:4]} + 16'h0010;
    k.w_act = MTG_ACT_SET;
    do_reset(k);
    watch <= 4'h1;
    expect_irq(4'h1, 400);
    repeat (2) @(posedge clk_i);
    check("wide pin", 16'h0001, {15'h0000, w_o});
    $display("test done: wide timer match");
    results();
  end
endmodule : mtg_timer_group_tb

`default_nettype wire
